// ==== rtl/msc_pkg.sv ====
// shared constants, command codes and carrier types of the measurement state command unit
package msc_pkg;

  // ==========================================================================
  // sizes
  localparam int MSC_NUM_AN = 3;

  // ==========================================================================
  // completion flag word layout
  localparam logic [31:0] MSC_FLAGS_RST = 32'h0000_0000;
  localparam int MSC_B_NONHARM = 0;
  localparam int MSC_B_MOTOR   = 3;
  localparam int MSC_B_HARM    = 8;
  localparam int MSC_B_SPECT   = 16;

  // ==========================================================================
  // command codes, already parsed from the remote text form
  typedef enum logic [3:0] {
    OP_CLR_INRUSH = 4'h0,
    OP_LOG_SET    = 4'h1,
    OP_LOG_Q      = 4'h2,
    OP_HIST_SET   = 4'h3,
    OP_HIST_Q     = 4'h4,
    OP_HOLD_SET   = 4'h5,
    OP_HOLD_Q     = 4'h6,
    OP_ACCUMULATION_CONTROL_SET  = 4'h7,
    OP_ACCUMULATION_CONTROL_Q    = 4'h8,
    OP_FLAGS_Q    = 4'h9,
    OP_SCOPE_SET  = 4'ha,
    OP_SCOPE_Q    = 4'hb,
    OP_IDLE_RUN   = 4'hc,
    OP_IDLE_Q     = 4'hd
  } msc_op_t;

  // ==========================================================================
  // value limits and status codes
  localparam logic [7:0] MSC_MAX_BOOL  = 8'h01;
  localparam logic [7:0] MSC_MAX_SCOPE = 8'h02;
  localparam logic [2:0] MSC_CAUSE_NONE = 3'h0;

  localparam logic [1:0] MSC_SCOPE_STOP   = 2'h0;
  localparam logic [1:0] MSC_SCOPE_SINGLE = 2'h1;
  localparam logic [1:0] MSC_SCOPE_CONT   = 2'h2;

  localparam logic [1:0] MSC_ACCUMULATION_CONTROL_OFF  = 2'h0;
  localparam logic [1:0] MSC_ACCUMULATION_CONTROL_WAIT = 2'h1;
  localparam logic [1:0] MSC_ACCUMULATION_CONTROL_HELD = 2'h2;
  localparam logic [1:0] MSC_ACCUMULATION_CONTROL_RUN  = 2'h3;

  localparam logic [2:0] MSC_SCQ_STOP_NODATA = 3'h0;
  localparam logic [2:0] MSC_SCQ_STOP_DATA   = 3'h1;
  localparam logic [2:0] MSC_SCQ_SINGLE      = 3'h2;
  localparam logic [2:0] MSC_SCQ_CONT_NODATA = 3'h3;
  localparam logic [2:0] MSC_SCQ_CONT_DATA   = 3'h4;

  // ==========================================================================
  // idle power run state per analyzer instance
  typedef enum logic [6:0] {
    SB_NONE   = 7'h01,
    SB_OPSTOP = 7'h02,
    SB_DONE   = 7'h04,
    SB_WAIT   = 7'h08,
    SB_MIN    = 7'h10,
    SB_EXT    = 7'h20,
    SB_RUN    = 7'h40
  } msc_sb_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       valid;
    msc_op_t    op;
    logic [1:0] sel;
    logic [7:0] value;
  } msc_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] f1;
    logic [2:0]  f2;
  } msc_rsp_t;

endpackage

// ==== rtl/msc_flag_word.sv ====
// completion flag word: or-accumulating flags, cleared on read or on configuration commit
`timescale 1ns/1ps
module msc_flag_word
  import msc_pkg::*;
(
  input  logic        clk,
  input  logic        rst,
  input  logic        ce,
  input  logic [31:0] set,
  input  logic        rd,
  input  logic        commit,
  output logic [31:0] flags
);

  // ==========================================================================
  // state
  logic [31:0] flags_reg;
  logic [31:0] flags_next;

  always_comb begin
    flags_next = flags_reg;
    if (rd || commit) begin
      flags_next = MSC_FLAGS_RST;
    end
    // a flag that lands in the clearing cycle survives for the next read
    flags_next = flags_next | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= MSC_FLAGS_RST;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

  // ==========================================================================
  // checks
  chk_flags_clear: assert property (@(posedge clk) disable iff (rst)
    (ce && rd && set == 32'h0) |=> (flags_reg == 32'h0))
    else $error("flag word not cleared after read");

  chk_flags_or: assert property (@(posedge clk) disable iff (rst)
    (ce && !rd && !commit) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag word lost a bit without a clear");

  chk_commit_clear: assert property (@(posedge clk) disable iff (rst)
    (ce && commit && set == 32'h0) |=> (flags_reg == 32'h0))
    else $error("flag word not cleared on commit");

endmodule // msc_flag_word

// ==== rtl/msc_unit.sv ====
// measurement state command unit: command interpreter and activity state
`timescale 1ns/1ps
module msc_unit
  import msc_pkg::*;
#(
  parameter int NUM_AN = MSC_NUM_AN
) (
  input  logic              MCLK,
  input  logic              RST,
  input  logic              CE,
  input  msc_cmd_t          CMD,
  input  logic [NUM_AN-1:0] AVAIL,
  input  logic              INRUSH_PERIOD_DONE,
  input  logic              LOG_TERM,
  input  logic [2:0]        LOG_TERM_CAUSE,
  input  logic              ACCUMULATION_CONTROL_DELAY_EN,
  input  logic              ACCUMULATION_CONTROL_DELAY_DONE,
  input  logic              SCOPE_CAPTURED,
  input  logic [NUM_AN-1:0] STBY_DELAYED,
  input  logic [NUM_AN-1:0] STBY_DETECT,
  input  logic [NUM_AN-1:0] STBY_MIN_DONE,
  input  logic [NUM_AN-1:0] STBY_END,
  input  logic [NUM_AN-1:0] NONHARM_DONE,
  input  logic              MOTOR_DONE,
  input  logic [NUM_AN-1:0] HARM_DONE,
  input  logic              SPECTRUM_DONE,
  input  logic              CFG_COMMIT,
  output msc_rsp_t          RSP,
  output logic              INRUSH_CLEAR,
  output logic              INRUSH_INVALID,
  output logic              LOG_ACTIVE,
  output logic [2:0]        LOG_CAUSE,
  output logic              HIST_ACTIVE,
  output logic              HIST_CLEAR,
  output logic              HOLD_ACTIVE,
  output logic [1:0]        ACCUMULATION_CONTROL_STATE,
  output logic              ACCUMULATION_CONTROL_CLEAR,
  output logic [1:0]        SCOPE_MODE,
  output logic              SCOPE_CLEAR,
  output logic [NUM_AN-1:0] STBY_START,
  output logic [NUM_AN-1:0] STBY_STOP
);

  // ==========================================================================
  // decoding helpers
  function automatic logic sel_ok(input logic [1:0] sel, input logic [NUM_AN-1:0] avail);
    logic ok;
    ok = (sel != 2'h0) && (int'(sel) <= NUM_AN);
    if (ok) begin
      ok = avail[sel - 2'h1];
    end
    return ok;
  endfunction

  function automatic logic [2:0] sb_code(input msc_sb_t s);
    logic [2:0] c;
    c = 3'h0;
    case (s)
      SB_NONE:   c = 3'h0;
      SB_OPSTOP: c = 3'h1;
      SB_DONE:   c = 3'h2;
      SB_WAIT:   c = 3'h3;
      SB_MIN:    c = 3'h4;
      SB_EXT:    c = 3'h5;
      SB_RUN:    c = 3'h6;
      default:   c = 3'h0;
    endcase
    return c;
  endfunction

  // ==========================================================================
  // state
  msc_rsp_t          rsp_reg,      rsp_next;
  logic              inr_clr_reg,  inr_clr_next;
  logic              inr_inv_reg,  inr_inv_next;
  logic              log_reg,      log_next;
  logic [2:0]        cause_reg,    cause_next;
  logic              hist_reg,     hist_next;
  logic              hclr_reg,     hclr_next;
  logic              hold_reg,     hold_next;
  logic              irun_reg,     irun_next;
  logic              iwait_reg,    iwait_next;
  logic [1:0]        icode_reg,    icode_next;
  logic              iclr_reg,     iclr_next;
  logic [1:0]        smode_reg,    smode_next;
  logic              sdata_reg,    sdata_next;
  logic              sclr_reg,     sclr_next;
  msc_sb_t           sb_reg [NUM_AN];
  msc_sb_t           sb_next [NUM_AN];
  logic [NUM_AN-1:0] sbst_reg,     sbst_next;
  logic [NUM_AN-1:0] sbsp_reg,     sbsp_next;
  logic [31:0]       flag_set;
  logic [31:0]       flags;
  logic              flag_rd;
  logic              is_set;
  logic              val_bool;
  logic [NUM_AN-1:0] run_hit;

  // ==========================================================================
  // completion flag word
  always_comb begin
    flag_set = 32'h0;
    for (int k = 0; k < NUM_AN; k++) begin
      flag_set[MSC_B_NONHARM + k] = NONHARM_DONE[k];
      flag_set[MSC_B_HARM + k]    = HARM_DONE[k];
    end
    flag_set[MSC_B_MOTOR] = MOTOR_DONE;
    flag_set[MSC_B_SPECT] = SPECTRUM_DONE;
  end

  assign flag_rd = CMD.valid && (CMD.op == OP_FLAGS_Q);

  msc_flag_word u_flags (
    .clk    (MCLK),
    .rst    (RST),
    .ce     (CE),
    .set    (flag_set),
    .rd     (flag_rd),
    .commit (CFG_COMMIT),
    .flags  (flags)
  );

  // ==========================================================================
  // command interpreter and single activities
  assign is_set   = CMD.valid;
  assign val_bool = (CMD.value <= MSC_MAX_BOOL);

  always_comb begin
    rsp_next     = '0;
    rsp_next.valid = CMD.valid;
    inr_clr_next = 1'b0;
    inr_inv_next = inr_inv_reg;
    log_next     = log_reg;
    cause_next   = cause_reg;
    hist_next    = hist_reg;
    hclr_next    = 1'b0;
    hold_next    = hold_reg;
    irun_next    = irun_reg;
    iwait_next   = iwait_reg;
    iclr_next    = 1'b0;
    smode_next   = smode_reg;
    sdata_next   = sdata_reg;
    sclr_next    = 1'b0;
    run_hit      = '0;
    // engine events first, so a command in the same cycle takes precedence
    if (INRUSH_PERIOD_DONE) begin
      inr_inv_next = 1'b0;
    end
    if (LOG_TERM && log_reg) begin
      log_next   = 1'b0;
      cause_next = LOG_TERM_CAUSE;
    end
    if (ACCUMULATION_CONTROL_DELAY_DONE) begin
      iwait_next = 1'b0;
    end
    if (SCOPE_CAPTURED && smode_reg != MSC_SCOPE_STOP) begin
      sdata_next = 1'b1;
      if (smode_reg == MSC_SCOPE_SINGLE) begin
        smode_next = MSC_SCOPE_STOP;
      end
    end
    if (is_set) begin
      case (CMD.op)
        OP_CLR_INRUSH: begin
          inr_clr_next = 1'b1;
          inr_inv_next = 1'b1;
        end
        OP_LOG_SET: begin
          if (!val_bool) begin
            rsp_next.err = 1'b1;
          end else begin
            log_next = CMD.value[0];
            if (CMD.value[0]) begin
              cause_next = MSC_CAUSE_NONE;
            end
          end
        end
        OP_LOG_Q: begin
          rsp_next.f1 = 32'(log_reg);
          rsp_next.f2 = cause_reg;
        end
        OP_HIST_SET: begin
          if (!val_bool) begin
            rsp_next.err = 1'b1;
          end else begin
            hist_next = CMD.value[0];
            hclr_next = CMD.value[0];
          end
        end
        OP_HIST_Q:   rsp_next.f1 = 32'(hist_reg);
        OP_HOLD_SET: begin
          if (!val_bool) begin
            rsp_next.err = 1'b1;
          end else begin
            hold_next = CMD.value[0];
          end
        end
        OP_HOLD_Q:   rsp_next.f1 = 32'(hold_reg);
        OP_ACCUMULATION_CONTROL_SET: begin
          if (!val_bool) begin
            rsp_next.err = 1'b1;
          end else begin
            irun_next  = CMD.value[0];
            iwait_next = CMD.value[0] && ACCUMULATION_CONTROL_DELAY_EN;
            iclr_next  = CMD.value[0];
          end
        end
        OP_ACCUMULATION_CONTROL_Q:  rsp_next.f1 = 32'(icode_reg);
        OP_FLAGS_Q:  rsp_next.f1 = flags;
        OP_SCOPE_SET: begin
          if (CMD.value > MSC_MAX_SCOPE) begin
            rsp_next.err = 1'b1;
          end else begin
            smode_next = CMD.value[1:0];
            if (CMD.value != 8'h00) begin
              sdata_next = 1'b0;
              sclr_next  = 1'b1;
            end
          end
        end
        OP_SCOPE_Q: begin
          if (smode_reg == MSC_SCOPE_SINGLE) begin
            rsp_next.f1 = 32'(MSC_SCQ_SINGLE);
          end else if (smode_reg == MSC_SCOPE_CONT) begin
            rsp_next.f1 = 32'(sdata_reg ? MSC_SCQ_CONT_DATA : MSC_SCQ_CONT_NODATA);
          end else begin
            rsp_next.f1 = 32'(sdata_reg ? MSC_SCQ_STOP_DATA : MSC_SCQ_STOP_NODATA);
          end
        end
        OP_IDLE_RUN: begin
          if (!sel_ok(CMD.sel, AVAIL) || !val_bool) begin
            rsp_next.err = 1'b1;
          end else begin
            run_hit[CMD.sel - 2'h1] = 1'b1;
          end
        end
        OP_IDLE_Q: begin
          if (!sel_ok(CMD.sel, AVAIL)) begin
            rsp_next.err = 1'b1;
          end else begin
            rsp_next.f1 = 32'(sb_code(sb_reg[CMD.sel - 2'h1]));
          end
        end
        default: rsp_next.err = 1'b1;
      endcase
    end
    // status code is registered so the output stays a flip-flop
    if (!irun_next) begin
      icode_next = MSC_ACCUMULATION_CONTROL_OFF;
    end else if (iwait_next) begin
      icode_next = MSC_ACCUMULATION_CONTROL_WAIT;
    end else if (hold_next) begin
      icode_next = MSC_ACCUMULATION_CONTROL_HELD;
    end else begin
      icode_next = MSC_ACCUMULATION_CONTROL_RUN;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rsp_reg     <= '0;
      inr_clr_reg <= 1'b0;
      inr_inv_reg <= 1'b0;
      log_reg     <= 1'b0;
      cause_reg   <= MSC_CAUSE_NONE;
      hist_reg    <= 1'b0;
      hclr_reg    <= 1'b0;
      hold_reg    <= 1'b0;
      irun_reg    <= 1'b0;
      iwait_reg   <= 1'b0;
      icode_reg   <= MSC_ACCUMULATION_CONTROL_OFF;
      iclr_reg    <= 1'b0;
      smode_reg   <= MSC_SCOPE_STOP;
      sdata_reg   <= 1'b0;
      sclr_reg    <= 1'b0;
    end else if (CE) begin
      rsp_reg     <= rsp_next;
      inr_clr_reg <= inr_clr_next;
      inr_inv_reg <= inr_inv_next;
      log_reg     <= log_next;
      cause_reg   <= cause_next;
      hist_reg    <= hist_next;
      hclr_reg    <= hclr_next;
      hold_reg    <= hold_next;
      irun_reg    <= irun_next;
      iwait_reg   <= iwait_next;
      icode_reg   <= icode_next;
      iclr_reg    <= iclr_next;
      smode_reg   <= smode_next;
      sdata_reg   <= sdata_next;
      sclr_reg    <= sclr_next;
    end
  end

  // ==========================================================================
  // idle power run, one state machine per analyzer instance
  for (genvar i = 0; i < NUM_AN; i++) begin : g_sb
    always_comb begin
      sb_next[i]   = sb_reg[i];
      sbst_next[i] = 1'b0;
      sbsp_next[i] = 1'b0;
      if (run_hit[i] && CMD.value[0]) begin
        sbst_next[i] = 1'b1;
        sb_next[i]   = STBY_DELAYED[i] ? SB_WAIT : SB_MIN;
      end else if (run_hit[i]) begin
        sbsp_next[i] = 1'b1;
        case (sb_reg[i])
          SB_WAIT:                sb_next[i] = SB_NONE;
          SB_MIN, SB_EXT, SB_RUN: sb_next[i] = SB_OPSTOP;
          default:                sb_next[i] = sb_reg[i];
        endcase
      end else begin
        case (sb_reg[i])
          SB_WAIT: if (STBY_DETECT[i]) begin
            sb_next[i] = SB_RUN;
          end
          SB_MIN: if (STBY_END[i]) begin
            sb_next[i] = SB_DONE;
          end else if (STBY_MIN_DONE[i]) begin
            sb_next[i] = SB_EXT;
          end
          SB_EXT, SB_RUN: if (STBY_END[i]) begin
            sb_next[i] = SB_DONE;
          end
          default: sb_next[i] = sb_reg[i];
        endcase
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        sb_reg[i]   <= SB_NONE;
        sbst_reg[i] <= 1'b0;
        sbsp_reg[i] <= 1'b0;
      end else if (CE) begin
        sb_reg[i]   <= sb_next[i];
        sbst_reg[i] <= sbst_next[i];
        sbsp_reg[i] <= sbsp_next[i];
      end
    end
  end

  // ==========================================================================
  // outputs
  assign RSP            = rsp_reg;
  assign INRUSH_CLEAR   = inr_clr_reg;
  assign INRUSH_INVALID = inr_inv_reg;
  assign LOG_ACTIVE     = log_reg;
  assign LOG_CAUSE      = cause_reg;
  assign HIST_ACTIVE    = hist_reg;
  assign HIST_CLEAR     = hclr_reg;
  assign HOLD_ACTIVE    = hold_reg;
  assign ACCUMULATION_CONTROL_STATE    = icode_reg;
  assign ACCUMULATION_CONTROL_CLEAR    = iclr_reg;
  assign SCOPE_MODE     = smode_reg;
  assign SCOPE_CLEAR    = sclr_reg;
  assign STBY_START     = sbst_reg;
  assign STBY_STOP      = sbsp_reg;

  // ==========================================================================
  // checks
  chk_sel_reject: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_IDLE_RUN && CMD.sel == 2'h0)
    |=> (RSP.valid && RSP.err && STBY_START == '0))
    else $error("bad selector not rejected");

  chk_inrush_inv: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_CLR_INRUSH) |=> (INRUSH_INVALID && INRUSH_CLEAR))
    else $error("surge clear did not invalidate");

  chk_log_start: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_LOG_SET && CMD.value == 8'h01)
    |=> (LOG_ACTIVE && LOG_CAUSE == 3'h0))
    else $error("logging start wrong");

  chk_log_query: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_LOG_Q)
    |=> (RSP.f1 == 32'($past(LOG_ACTIVE)) && RSP.f2 == $past(LOG_CAUSE)))
    else $error("logging query wrong");

  chk_hist_clear: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_HIST_SET && CMD.value == 8'h01)
    |=> (HIST_CLEAR && HIST_ACTIVE) ##1 (!HIST_CLEAR || !$past(CE)
    || $past(CMD.valid && CMD.op == OP_HIST_SET && CMD.value == 8'h01)))
    else $error("trend restart did not erase");

  chk_hold_echo: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_HOLD_Q) |=> (RSP.f1 == 32'($past(HOLD_ACTIVE))))
    else $error("freeze query mismatch");

  chk_accumulation_control_code: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_ACCUMULATION_CONTROL_SET && CMD.value == 8'h01 && ACCUMULATION_CONTROL_DELAY_EN)
    |=> (ACCUMULATION_CONTROL_CLEAR && ACCUMULATION_CONTROL_STATE == 2'h1))
    else $error("accumulation start not waiting");

  chk_scope_clear: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_SCOPE_SET && CMD.value == 8'h02)
    |=> (SCOPE_CLEAR && SCOPE_MODE == 2'h2))
    else $error("capture start did not discard");

  chk_range_reject: assert property (@(posedge MCLK) disable iff (RST)
    (CE && CMD.valid && CMD.op == OP_HOLD_SET && CMD.value > 8'h01)
    |=> (RSP.err && $stable(HOLD_ACTIVE)))
    else $error("out of range value accepted");

endmodule // msc_unit

// ==== sim/msc_host_model.sv ====
// remote host model: issues one parsed command and captures the registered answer
`timescale 1ns/1ps
module msc_host_model
  import msc_pkg::*;
(
  input  wire logic     clk,
  output msc_cmd_t      cmd,
  input  wire msc_rsp_t rsp
);
  initial cmd = '0;

  // ====
  // transfer
  // request launched after one edge, taken at the next; the answer is registered at that edge
  task automatic xfer(input msc_op_t op, input logic [1:0] sel, input logic [7:0] val,
                      output msc_rsp_t r);
    @(posedge clk);
    cmd <= '{1'b1, op, sel, val};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    r = rsp;
  endtask
endmodule // msc_host_model

// ==== sim/measurement_state_command_unit_tb_top.sv ====
// self-checking testbench of the measurement state command unit
`timescale 1ns/1ps
module measurement_state_command_unit_tb_top;
  import msc_pkg::*;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  msc_cmd_t   cmd;
  msc_rsp_t   rsp;
  msc_rsp_t   r;
  logic [2:0] avail = 3'h3, dly = 3'h0, det = 3'h0, mind = 3'h0, send = 3'h0;
  logic [2:0] nh = 3'h0, hm = 3'h0, cause = 3'h0, sb_start, sb_stop, log_cause;
  logic       ipd = 1'b0, lt = 1'b0, den = 1'b0, ddone = 1'b0, cap = 1'b0;
  logic       mot = 1'b0, spc = 1'b0, com = 1'b0, ce = 1'b1;
  logic       inr_clr, inr_inv, log_act, hist_act, hist_clr, hold_act, accumulation_control_clr, scope_clr;
  logic [1:0] accumulation_control_state, scope_mode;
  int         errors = 0;
  int         check_count = 0;

  initial forever #25 mclk = ~mclk;

  msc_host_model host (.clk(mclk), .cmd(cmd), .rsp(rsp));

  msc_unit dut (
    .MCLK(mclk), .RST(rst), .CE(ce), .CMD(cmd), .AVAIL(avail),
    .INRUSH_PERIOD_DONE(ipd), .LOG_TERM(lt), .LOG_TERM_CAUSE(cause),
    .ACCUMULATION_CONTROL_DELAY_EN(den), .ACCUMULATION_CONTROL_DELAY_DONE(ddone), .SCOPE_CAPTURED(cap),
    .STBY_DELAYED(dly), .STBY_DETECT(det), .STBY_MIN_DONE(mind), .STBY_END(send),
    .NONHARM_DONE(nh), .MOTOR_DONE(mot), .HARM_DONE(hm), .SPECTRUM_DONE(spc),
    .CFG_COMMIT(com), .RSP(rsp), .INRUSH_CLEAR(inr_clr), .INRUSH_INVALID(inr_inv),
    .LOG_ACTIVE(log_act), .LOG_CAUSE(log_cause), .HIST_ACTIVE(hist_act),
    .HIST_CLEAR(hist_clr), .HOLD_ACTIVE(hold_act), .ACCUMULATION_CONTROL_STATE(accumulation_control_state),
    .ACCUMULATION_CONTROL_CLEAR(accumulation_control_clr), .SCOPE_MODE(scope_mode), .SCOPE_CLEAR(scope_clr),
    .STBY_START(sb_start), .STBY_STOP(sb_stop)
  );

  // ====
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic go(input msc_op_t op, input logic [1:0] sel, input logic [7:0] val);
    host.xfer(op, sel, val, r);
  endtask

  task automatic q(input msc_op_t op, input logic [1:0] sel, input logic [31:0] exp);
    go(op, sel, 8'h00);
    check("answer", r.f1, exp);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ====
  // scenarios
  task automatic t_log;
    go(OP_LOG_SET, 2'h0, 8'h01);
    check("log_act", log_act, 1'b1);
    @(posedge mclk) begin
      lt <= 1'b1;
      cause <= 3'h2;
    end
    @(posedge mclk) lt <= 1'b0;
    go(OP_LOG_Q, 2'h0, 8'h00);
    check("log_idle", r.f1, 32'h0);
    check("cause_kept", r.f2, 3'h2);
    check("log_cause", log_cause, 3'h2);
    go(OP_LOG_SET, 2'h0, 8'h02);
    check("range_err", r.err, 1'b1);
    check("log_unchanged", log_act, 1'b0);
    go(OP_LOG_SET, 2'h0, 8'h01);
    check("cause_cleared", log_cause, 3'h0);
    go(OP_LOG_Q, 2'h0, 8'h00);
    check("log_busy", r.f1, 32'h1);
    check("cause_zeroed", r.f2, 3'h0);
    go(OP_LOG_SET, 2'h0, 8'h00);
    check("log_stop", log_act, 1'b0);
  endtask

  task automatic t_hist;
    go(OP_HIST_SET, 2'h0, 8'h01);
    check("hist_erase", hist_clr, 1'b1);
    check("hist_on", hist_act, 1'b1);
    q(OP_HIST_Q, 2'h0, 32'h1);
    go(OP_HIST_SET, 2'h0, 8'h00);
    check("hist_no_erase", hist_clr, 1'b0);
    check("hist_off", hist_act, 1'b0);
    q(OP_HIST_Q, 2'h0, 32'h0);
  endtask

  task automatic t_accumulation_control;
    @(posedge mclk) den <= 1'b1;
    go(OP_ACCUMULATION_CONTROL_SET, 2'h0, 8'h01);
    check("accumulation_control_clear", accumulation_control_clr, 1'b1);
    check("accumulation_control_state", accumulation_control_state, 2'h1);
    q(OP_ACCUMULATION_CONTROL_Q, 2'h0, 32'h1);
    @(posedge mclk) ddone <= 1'b1;
    @(posedge mclk) ddone <= 1'b0;
    q(OP_ACCUMULATION_CONTROL_Q, 2'h0, 32'h3);
    go(OP_HOLD_SET, 2'h0, 8'h01);
    check("hold_act", hold_act, 1'b1);
    q(OP_HOLD_Q, 2'h0, 32'h1);
    q(OP_ACCUMULATION_CONTROL_Q, 2'h0, 32'h2);
    go(OP_HOLD_SET, 2'h0, 8'h00);
    q(OP_HOLD_Q, 2'h0, 32'h0);
    go(OP_ACCUMULATION_CONTROL_SET, 2'h0, 8'h00);
    q(OP_ACCUMULATION_CONTROL_Q, 2'h0, 32'h0);
  endtask

  task automatic t_flags;
    @(posedge mclk) begin
      nh <= 3'h1;
      hm <= 3'h2;
      mot <= 1'b1;
    end
    @(posedge mclk) begin
      nh <= 3'h4;
      hm <= 3'h0;
      mot <= 1'b0;
      spc <= 1'b1;
    end
    @(posedge mclk) begin
      nh <= 3'h0;
      spc <= 1'b0;
    end
    q(OP_FLAGS_Q, 2'h0, 32'h0001_020d);
    q(OP_FLAGS_Q, 2'h0, 32'h0);
    @(posedge mclk) hm <= 3'h5;
    @(posedge mclk) hm <= 3'h0;
    q(OP_FLAGS_Q, 2'h0, 32'h0000_0500);
    @(posedge mclk) spc <= 1'b1;
    @(posedge mclk) spc <= 1'b0;
    @(posedge mclk) com <= 1'b1;
    @(posedge mclk) com <= 1'b0;
    q(OP_FLAGS_Q, 2'h0, 32'h0);
  endtask

  task automatic t_scope;
    go(OP_SCOPE_SET, 2'h0, 8'h02);
    check("scope_discard", scope_clr, 1'b1);
    check("scope_mode", scope_mode, 2'h2);
    q(OP_SCOPE_Q, 2'h0, 32'h3);
    @(posedge mclk) cap <= 1'b1;
    @(posedge mclk) cap <= 1'b0;
    q(OP_SCOPE_Q, 2'h0, 32'h4);
    go(OP_SCOPE_SET, 2'h0, 8'h01);
    q(OP_SCOPE_Q, 2'h0, 32'h2);
    @(posedge mclk) cap <= 1'b1;
    @(posedge mclk) cap <= 1'b0;
    q(OP_SCOPE_Q, 2'h0, 32'h1);
    go(OP_SCOPE_SET, 2'h0, 8'h03);
    check("scope_err", r.err, 1'b1);
    q(OP_SCOPE_Q, 2'h0, 32'h1);
  endtask

  task automatic t_idle;
    q(OP_IDLE_Q, 2'h1, 32'h0);
    go(OP_IDLE_RUN, 2'h3, 8'h01);
    check("absent_err", r.err, 1'b1);
    go(OP_IDLE_RUN, 2'h0, 8'h01);
    check("sel0_err", r.err, 1'b1);
    @(posedge mclk) dly <= 3'h1;
    go(OP_IDLE_RUN, 2'h1, 8'h01);
    check("sb_start", sb_start, 3'h1);
    q(OP_IDLE_Q, 2'h1, 32'h3);
    @(posedge mclk) det <= 3'h1;
    @(posedge mclk) det <= 3'h0;
    q(OP_IDLE_Q, 2'h1, 32'h6);
    go(OP_IDLE_RUN, 2'h1, 8'h00);
    check("sb_stop", sb_stop, 3'h1);
    q(OP_IDLE_Q, 2'h1, 32'h1);
    go(OP_IDLE_RUN, 2'h2, 8'h01);
    q(OP_IDLE_Q, 2'h2, 32'h4);
    @(posedge mclk) mind <= 3'h2;
    @(posedge mclk) mind <= 3'h0;
    q(OP_IDLE_Q, 2'h2, 32'h5);
    @(posedge mclk) send <= 3'h2;
    @(posedge mclk) send <= 3'h0;
    q(OP_IDLE_Q, 2'h2, 32'h2);
  endtask

  task automatic t_inrush;
    go(OP_CLR_INRUSH, 2'h0, 8'h00);
    check("inr_clear", inr_clr, 1'b1);
    check("inr_invalid", inr_inv, 1'b1);
    @(posedge mclk) ipd <= 1'b1;
    @(posedge mclk) ipd <= 1'b0;
    #1;
    check("inr_valid", inr_inv, 1'b0);
  endtask

  // a command offered while the enable is low must be neither taken nor answered
  task automatic t_freeze;
    @(posedge mclk) ce <= 1'b0;
    go(OP_HOLD_SET, 2'h0, 8'h01);
    check("frozen_hold", hold_act, 1'b0);
    check("frozen_rsp", r.valid, 1'b0);
    @(posedge mclk) ce <= 1'b1;
    q(OP_HOLD_Q, 2'h0, 32'h0);
  endtask

  // mid-run reset must drop capture data and idle run results
  task automatic t_reset;
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    q(OP_SCOPE_Q, 2'h0, 32'h0);
    q(OP_IDLE_Q, 2'h2, 32'h0);
  endtask

  // ====
  // main sequence and hang guard
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    q(OP_FLAGS_Q, 2'h0, 32'h0);
    t_log();
    t_hist();
    t_accumulation_control();
    t_flags();
    t_scope();
    t_idle();
    t_inrush();
    t_freeze();
    t_reset();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end
endmodule // measurement_state_command_unit_tb_top
